// File: hdl/pch_pkg.sv
// Purpose: Shared constants for the configuration header register slice
// Assumes: Configuration port addresses whole dwords of the header
// Notes:   Offsets are dword indices within the configuration header
package pch_pkg;

  // ----------------------------------------------------------------------
  // Configuration header dword map
  // ----------------------------------------------------------------------
  localparam logic [5:0] CFG_DW_MISC = 6'h03;
  localparam logic [5:0] CFG_DW_BAR0 = 6'h04;
  localparam int         NUM_BAR_MAX = 6;

  // ----------------------------------------------------------------------
  // Byte lanes within the misc dword
  // ----------------------------------------------------------------------
  localparam int LINE_BYTE   = 0;
  localparam int HOLD_BYTE   = 1;
  localparam int LAYOUT_BYTE = 2;

  // ----------------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  LINE_SIZE_RST  = 8'h00;
  localparam logic [7:0]  HOLD_LIMIT_RST = 8'h00;
  localparam logic [7:0]  HOLD_WR_MASK   = 8'hf8;
  localparam logic [7:0]  LAYOUT_VALUE   = 8'h00;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Window register fields
  // ----------------------------------------------------------------------
  localparam int          SPACE_BIT    = 0;
  localparam int          TYPE_LSB     = 1;
  localparam int          PREF_BIT     = 3;
  localparam logic [1:0]  MEM_TYPE_32  = 2'b00;
  localparam logic [1:0]  MEM_TYPE_64  = 2'b10;
  localparam logic [31:0] MEM_RO_MASK  = 32'h0000_000f;
  localparam logic [31:0] MEM_ADR_MASK = 32'hffff_fff0;
  localparam logic [31:0] IO_ADR_MASK  = 32'hffff_fffc;
  localparam logic [31:0] IO_RO_VALUE  = 32'h0000_0001;

endpackage

// File: hdl/pch_hold_counter.sv
// Purpose: Bus hold countdown for an initiated transaction
// Assumes: start and owning come from logic on the same clock
// Notes:   Expiry stays up while the bus is still owned at zero
`timescale 1ns/1ps
`default_nettype none
module pch_hold_counter #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic         owning,
  input  wire logic [W-1:0] limit,
  output logic      [W-1:0] count_r,
  output logic              expired_r
);
  import pch_pkg::*;

  if (W < 1) begin : g_bad_width
    $error("hold counter width must be at least 1");
  end

  // ----------------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r   <= '0;
      expired_r <= 1'b0;
    end else if (start) begin
      count_r   <= limit;
      expired_r <= (limit == '0);
    end else if (owning) begin
      if (count_r != '0) begin
        count_r <= count_r - W'(1);
      end
      expired_r <= (count_r <= W'(1));
    end else begin
      expired_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_step_one;
    @(posedge core_clk) disable iff (sys_rst)
      (!start && owning && count_r != '0) |=> (count_r == $past(count_r) - W'(1));
  endproperty
  a_step_one: assert property (p_step_one) else $error("hold count did not step by one");

  property p_load;
    @(posedge core_clk) disable iff (sys_rst)
      start |=> (count_r == $past(limit));
  endproperty
  a_load: assert property (p_load) else $error("hold count not loaded at start");

  property p_expire;
    @(posedge core_clk) disable iff (sys_rst)
      (!start && owning && count_r == W'(1)) |=> (expired_r && count_r == '0);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry missed at zero");

endmodule
`default_nettype wire

// File: hdl/pch_window_reg.sv
// Purpose: One base address window register
// Assumes: Masks are worked out by the parent at elaboration
// Notes:   Read-only bits hold RO_VALUE for ever
`timescale 1ns/1ps
`default_nettype none
module pch_window_reg #(
  parameter logic [31:0] WR_MASK  = 32'h0000_0000,
  parameter logic [31:0] RO_VALUE = 32'h0000_0000
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [3:0]  byte_en,
  input  wire logic [31:0] wdata,
  output logic      [31:0] value_r
);
  import pch_pkg::*;

  logic [31:0] lane_mask;
  logic [31:0] wr_bits;

  always_comb begin
    lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
    wr_bits   = lane_mask & WR_MASK;
  end

  // Only the size-defined address bits take write data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_r <= RO_VALUE;
    end else if (wr_en) begin
      value_r <= (value_r & ~wr_bits) | (wdata & wr_bits);
    end
  end

  property p_fixed_bits;
    @(posedge core_clk) disable iff (sys_rst)
      ((value_r & ~WR_MASK) == RO_VALUE);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed window bits changed");

endmodule
`default_nettype wire

// File: hdl/pch_config_header_regs.sv
// Purpose: Line size, bus hold limit, layout and window registers of a
//          configuration header, with the hold countdown
// Assumes: Configuration accesses arrive decoded to a dword index
// Notes:   Reads answer one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module pch_config_header_regs #(
  parameter bit                MASTER_CAPABLE       = 1'b1,
  parameter int                NUM_WINDOWS          = 1,
  parameter int                UPPER_WR_BITS        = 8,
  parameter logic [5:0][31:0]  WINDOW_SETTING_PARAM = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff00_0000}
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 cfg_wr_en,
  input  wire logic                 cfg_rd_en,
  input  wire logic [5:0]           cfg_dw_addr,
  input  wire logic [3:0]           cfg_byte_en,
  input  wire logic [31:0]          cfg_wdata,
  input  wire logic                 txn_start,
  input  wire logic                 master_active,
  output logic      [31:0]          cfg_rdata_r,
  output logic                      cfg_rd_valid_r,
  output logic      [7:0]           line_size_r,
  output logic      [7:0]           bus_hold_limit_r,
  output logic      [7:0]           hold_count_r,
  output logic                      hold_expired_r,
  output logic      [5:0][31:0]     window_base_r
);
  import pch_pkg::*;

  // ----------------------------------------------------------------------
  // Window attribute functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] f_setting(input int n);
    f_setting = WINDOW_SETTING_PARAM[n];
  endfunction

  function automatic bit f_is_low64(input int n);
    logic [31:0] s;
    s = f_setting(n);
    f_is_low64 = (n < NUM_WINDOWS) && !s[SPACE_BIT] && (s[TYPE_LSB+:2] == MEM_TYPE_64);
  endfunction

  function automatic bit f_is_upper(input int n);
    f_is_upper = (n > 0) && f_is_low64(n - 1);
  endfunction

  function automatic logic [31:0] f_wr_mask(input int n);
    logic [31:0] s;
    logic [31:0] m;
    s = f_setting(n);
    m = ZERO_WORD;
    if (n >= NUM_WINDOWS) begin
      m = ZERO_WORD;
    end else if (f_is_upper(n)) begin
      for (int i = 0; i < 32; i++) begin
        m[i] = (i < UPPER_WR_BITS);
      end
    end else if (s[SPACE_BIT]) begin
      m = s & IO_ADR_MASK;
    end else if (f_is_low64(n)) begin
      m = MEM_ADR_MASK;
    end else begin
      m = s & MEM_ADR_MASK;
    end
    f_wr_mask = m;
  endfunction

  function automatic logic [31:0] f_ro_value(input int n);
    logic [31:0] s;
    logic [31:0] v;
    s = f_setting(n);
    v = ZERO_WORD;
    if (n >= NUM_WINDOWS || f_is_upper(n)) begin
      v = ZERO_WORD;
    end else if (s[SPACE_BIT]) begin
      v = IO_RO_VALUE;
    end else begin
      v = s & MEM_RO_MASK;
    end
    f_ro_value = v;
  endfunction

  function automatic bit f_contig(input logic [31:0] m);
    logic [31:0] inv;
    inv = ~m;
    f_contig = ((inv & (inv + 32'h0000_0001)) == ZERO_WORD);
  endfunction

  function automatic int f_count64();
    int c;
    c = 0;
    for (int n = 0; n < NUM_BAR_MAX; n++) begin
      if (f_is_low64(n)) begin
        c++;
      end
    end
    f_count64 = c;
  endfunction

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NUM_WINDOWS < 1 || NUM_WINDOWS > NUM_BAR_MAX) begin : g_bad_count
    $error("window count must be 1 to 6");
  end
  if (UPPER_WR_BITS < 1 || UPPER_WR_BITS > 32) begin : g_bad_upper
    $error("upper writable bit count must be 1 to 32");
  end
  if (f_count64() > 1) begin : g_bad_pairs
    $error("only one 64-bit window is allowed");
  end
  for (genvar g = 0; g < NUM_BAR_MAX; g++) begin : g_check
    if (g < NUM_WINDOWS && !f_is_upper(g)) begin : g_live
      if (!WINDOW_SETTING_PARAM[g][SPACE_BIT] &&
          WINDOW_SETTING_PARAM[g][TYPE_LSB+:2] != MEM_TYPE_32 &&
          WINDOW_SETTING_PARAM[g][TYPE_LSB+:2] != MEM_TYPE_64) begin : g_bad_type
        $error("unsupported memory placement");
      end
      if (f_is_low64(g) && (g > 1 || g + 1 >= NUM_WINDOWS)) begin : g_bad_pair
        $error("64-bit window must use pair 1:0 or 2:1");
      end
      if (!f_contig(f_wr_mask(g))) begin : g_bad_size
        $error("window size bits have gaps");
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  logic misc_wr;
  logic [NUM_BAR_MAX-1:0] win_wr;

  always_comb begin
    misc_wr = cfg_wr_en && (cfg_dw_addr == CFG_DW_MISC);
    for (int n = 0; n < NUM_BAR_MAX; n++) begin
      win_wr[n] = cfg_wr_en && (cfg_dw_addr == CFG_DW_BAR0 + 6'(n));
    end
  end

  // ----------------------------------------------------------------------
  // Line size register
  // ----------------------------------------------------------------------
  // Target-only builds keep it at reset so synthesis prunes it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_size_r <= LINE_SIZE_RST;
    end else if (MASTER_CAPABLE && misc_wr && cfg_byte_en[LINE_BYTE]) begin
      line_size_r <= cfg_wdata[8*LINE_BYTE+:8];
    end
  end

  // ----------------------------------------------------------------------
  // Bus hold limit register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_hold_limit_r <= HOLD_LIMIT_RST;
    end else if (MASTER_CAPABLE && misc_wr && cfg_byte_en[HOLD_BYTE]) begin
      bus_hold_limit_r <= cfg_wdata[8*HOLD_BYTE+:8] & HOLD_WR_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Hold countdown
  // ----------------------------------------------------------------------
  logic txn_start_m;
  logic master_active_m;

  // Target-only builds have no hold limit, so expiry must never rise there
  always_comb begin
    txn_start_m     = txn_start && MASTER_CAPABLE;
    master_active_m = master_active && MASTER_CAPABLE;
  end

  pch_hold_counter #(
    .W (8)
  ) u_hold (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .start     (txn_start_m),
    .owning    (master_active_m),
    .limit     (bus_hold_limit_r),
    .count_r   (hold_count_r),
    .expired_r (hold_expired_r)
  );

  // ----------------------------------------------------------------------
  // Window registers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NUM_BAR_MAX; g++) begin : g_win
    pch_window_reg #(
      .WR_MASK  (f_wr_mask(g)),
      .RO_VALUE (f_ro_value(g))
    ) u_win (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_en    (win_wr[g]),
      .byte_en  (cfg_byte_en),
      .wdata    (cfg_wdata),
      .value_r  (window_base_r[g])
    );
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;
  int          rd_idx;

  always_comb begin
    rd_word = ZERO_WORD;
    rd_idx  = int'(cfg_dw_addr) - int'(CFG_DW_BAR0);
    if (cfg_dw_addr == CFG_DW_MISC) begin
      rd_word[8*LINE_BYTE+:8]   = line_size_r;
      rd_word[8*HOLD_BYTE+:8]   = bus_hold_limit_r;
      rd_word[8*LAYOUT_BYTE+:8] = LAYOUT_VALUE;
    end else if (rd_idx >= 0 && rd_idx < NUM_BAR_MAX) begin
      rd_word = window_base_r[rd_idx];
    end else begin
      rd_word = ZERO_WORD;
    end
  end

  // Unmapped dwords answer zero rather than stalling the requester
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata_r    <= ZERO_WORD;
      cfg_rd_valid_r <= 1'b0;
    end else begin
      cfg_rd_valid_r <= cfg_rd_en;
      if (cfg_rd_en) begin
        cfg_rdata_r <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_line_write;
    @(posedge core_clk) disable iff (sys_rst)
      (MASTER_CAPABLE && cfg_wr_en && cfg_dw_addr == CFG_DW_MISC && cfg_byte_en[LINE_BYTE])
        |=> (line_size_r == $past(cfg_wdata[7:0]));
  endproperty
  a_line_write: assert property (p_line_write) else $error("line size write lost");

  property p_target_only;
    @(posedge core_clk) disable iff (sys_rst)
      !MASTER_CAPABLE |-> (line_size_r == 8'h00 && bus_hold_limit_r == 8'h00 && !hold_expired_r);
  endproperty
  a_target_only: assert property (p_target_only) else $error("master registers in target build");

  property p_hold_low_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (MASTER_CAPABLE && cfg_wr_en && cfg_dw_addr == CFG_DW_MISC && cfg_byte_en[HOLD_BYTE])
        |=> (bus_hold_limit_r == ($past(cfg_wdata[15:8]) & 8'hf8));
  endproperty
  a_hold_low_zero: assert property (p_hold_low_zero) else $error("hold limit write wrong");

  property p_layout_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg_rd_en && cfg_dw_addr == CFG_DW_MISC) |=> (cfg_rd_valid_r && cfg_rdata_r[23:16] == 8'h00);
  endproperty
  a_layout_zero: assert property (p_layout_zero) else $error("layout byte not zero");

  property p_win_read;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg_rd_en && cfg_dw_addr == CFG_DW_BAR0)
        |=> (cfg_rdata_r[0] == WINDOW_SETTING_PARAM[0][0] && cfg_rdata_r == $past(window_base_r[0]));
  endproperty
  a_win_read: assert property (p_win_read) else $error("window 0 read wrong");

  property p_unused_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg_rd_en && cfg_dw_addr >= CFG_DW_BAR0 + 6'(NUM_WINDOWS) && cfg_dw_addr < 6'h0a)
        |=> (cfg_rdata_r == 32'h0000_0000);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("absent window not zero");

  property p_rd_pulse;
    @(posedge core_clk) disable iff (sys_rst)
      cfg_rd_valid_r == $past(cfg_rd_en);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid not one cycle after request");

  property p_misc_read;
    @(posedge core_clk) disable iff (sys_rst)
      (cfg_rd_en && cfg_dw_addr == CFG_DW_MISC)
        |=> (cfg_rdata_r[8*LINE_BYTE+:8] == $past(line_size_r) &&
             cfg_rdata_r[8*HOLD_BYTE+:8] == $past(bus_hold_limit_r) &&
             cfg_rdata_r[31:24] == 8'h00);
  endproperty
  a_misc_read: assert property (p_misc_read) else $error("misc dword read wrong");

  // A write without the lane enabled must leave that byte alone
  property p_line_keep;
    @(posedge core_clk) disable iff (sys_rst)
      !(misc_wr && cfg_byte_en[LINE_BYTE]) |=> $stable(line_size_r);
  endproperty
  a_line_keep: assert property (p_line_keep) else $error("line size changed without write");

  property p_hold_keep;
    @(posedge core_clk) disable iff (sys_rst)
      !(misc_wr && cfg_byte_en[HOLD_BYTE]) |=> $stable(bus_hold_limit_r);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold limit changed without write");

  property p_hold_low_bits;
    @(posedge core_clk) disable iff (sys_rst)
      (bus_hold_limit_r & ~HOLD_WR_MASK) == 8'h00;
  endproperty
  a_hold_low_bits: assert property (p_hold_low_bits) else $error("hold limit low bits set");

  property p_target_count;
    @(posedge core_clk) disable iff (sys_rst)
      !MASTER_CAPABLE |-> (hold_count_r == 8'h00);
  endproperty
  a_target_count: assert property (p_target_count) else $error("hold count runs in target build");

  // Per-window read data and zero high bits of an upper half
  for (genvar g = 0; g < NUM_BAR_MAX; g++) begin : g_win_chk
    property p_win_read_any;
      @(posedge core_clk) disable iff (sys_rst)
        (cfg_rd_en && cfg_dw_addr == CFG_DW_BAR0 + 6'(g)) |=> (cfg_rdata_r == $past(window_base_r[g]));
    endproperty
    a_win_read_any: assert property (p_win_read_any) else $error("window read wrong");

    property p_upper_high_zero;
      @(posedge core_clk) disable iff (sys_rst)
        f_is_upper(g) |-> ((window_base_r[g] >> UPPER_WR_BITS) == ZERO_WORD);
    endproperty
    a_upper_high_zero: assert property (p_upper_high_zero) else $error("upper window high bits set");
  end

endmodule
`default_nettype wire

// File: dv/pch_host_model.sv
// Purpose: Host side configuration master for the header register slice
// Assumes: One request per task call, answer one cycle after it is taken
// Notes:   Released address, lane and data lines show the inverse of their last value; enables drop to zero
`timescale 1ns/1ps
`default_nettype none
module pch_host_model (
  input  wire logic        core_clk,
  output logic             cfg_wr_en,
  output logic             cfg_rd_en,
  output logic [5:0]       cfg_dw_addr,
  output logic [3:0]       cfg_byte_en,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata_r,
  input  wire logic        cfg_rd_valid_r
);
  initial begin
    cfg_wr_en   = 1'b0;
    cfg_rd_en   = 1'b0;
    cfg_dw_addr = 6'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata   = 32'h0000_0000;
  end

  // Stale values would let a sloppy decoder pass by luck
  task automatic release_bus();
    cfg_wr_en   <= 1'b0;
    cfg_rd_en   <= 1'b0;
    cfg_dw_addr <= ~cfg_dw_addr;
    cfg_byte_en <= ~cfg_byte_en;
    cfg_wdata   <= ~cfg_wdata;
  endtask

  task automatic cfg_write(input logic [5:0] adr, input logic [3:0] be, input logic [31:0] dat);
    @(posedge core_clk);
    cfg_wr_en   <= 1'b1;
    cfg_dw_addr <= adr;
    cfg_byte_en <= be;
    cfg_wdata   <= dat;
    @(posedge core_clk);
    release_bus();
  endtask

  task automatic cfg_read(input logic [5:0] adr, output logic [31:0] dat, output logic ok);
    @(posedge core_clk);
    cfg_rd_en   <= 1'b1;
    cfg_dw_addr <= adr;
    @(posedge core_clk);
    release_bus();
    #1;
    ok  = (cfg_rd_valid_r === 1'b1);
    dat = cfg_rdata_r;
  endtask
endmodule
`default_nettype wire

// File: dv/pch_config_header_regs_tb.sv
// Purpose: Self-checking bench for the configuration header register slice
// Assumes: Window 0/1 form a 64-bit pair, window 2 is I/O, window 3 is 32-bit
// Notes:   Target-only and 2:1-pair builds share the config bus
`timescale 1ns/1ps
`default_nettype none
module pch_config_header_regs_tb;
  import pch_pkg::*;
  localparam logic [5:0][31:0] WSET = {32'h0, 32'h0, 32'hff00_0000, 32'hffff_ff01, 32'h0, 32'hffff_fffc};
  localparam logic [5:0][31:0] WSET21 = {32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_fff4, 32'hfff0_0008};
  logic             core_clk;
  logic             sys_rst;
  logic             txn_start;
  logic             master_active;
  wire logic        wr_en;
  wire logic        rd_en;
  wire logic [5:0]  dw_addr;
  wire logic [3:0]  byte_en;
  wire logic [31:0] wdata;
  wire logic [31:0] rdata;
  wire logic        rd_valid;
  wire logic [7:0]  line_size_r;
  wire logic [7:0]  hold_limit_r;
  wire logic [7:0]  hold_count_r;
  wire logic        hold_expired_r;
  wire logic [5:0][31:0] window_base_r;
  wire logic [31:0] tgt_rdata;
  wire logic [7:0]  tgt_line_size;
  wire logic [7:0]  tgt_hold_limit;
  wire logic [7:0]  tgt_hold_count;
  wire logic        tgt_expired;
  wire logic [5:0][31:0] p21_win;
  int               err_total;
  int               compares;
  logic [31:0]      exp_hi [6] = '{32'hffff_fffc, 32'h0000_00ff, 32'hffff_ff01, 32'hff00_0000, 32'h0, 32'h0};
  logic [31:0]      exp_lo [6] = '{32'h0000_000c, 32'h0, 32'h0000_0001, 32'h0, 32'h0, 32'h0};
  logic [31:0]      exp21 [6] = '{32'hfff0_0008, 32'hffff_fff4, 32'h0000_000f, 32'h0, 32'h0, 32'h0};

  pch_host_model host (.core_clk(core_clk), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_dw_addr(dw_addr),
    .cfg_byte_en(byte_en), .cfg_wdata(wdata), .cfg_rdata_r(rdata), .cfg_rd_valid_r(rd_valid));

  pch_config_header_regs #(.NUM_WINDOWS(4), .UPPER_WR_BITS(8), .WINDOW_SETTING_PARAM(WSET)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_dw_addr(dw_addr),
    .cfg_byte_en(byte_en), .cfg_wdata(wdata), .txn_start(txn_start), .master_active(master_active),
    .cfg_rdata_r(rdata), .cfg_rd_valid_r(rd_valid), .line_size_r(line_size_r),
    .bus_hold_limit_r(hold_limit_r), .hold_count_r(hold_count_r), .hold_expired_r(hold_expired_r),
    .window_base_r(window_base_r));

  pch_config_header_regs #(.MASTER_CAPABLE(1'b0)) uut_tgt (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_dw_addr(dw_addr),
    .cfg_byte_en(byte_en), .cfg_wdata(wdata), .txn_start(txn_start), .master_active(master_active),
    .cfg_rdata_r(tgt_rdata), .cfg_rd_valid_r(), .line_size_r(tgt_line_size),
    .bus_hold_limit_r(tgt_hold_limit), .hold_count_r(tgt_hold_count), .hold_expired_r(tgt_expired),
    .window_base_r());

  // Second pairing choice: window 1 low half, window 2 upper half with four writable bits
  pch_config_header_regs #(.NUM_WINDOWS(3), .UPPER_WR_BITS(4), .WINDOW_SETTING_PARAM(WSET21)) uut_p21 (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_dw_addr(dw_addr),
    .cfg_byte_en(byte_en), .cfg_wdata(wdata), .txn_start(txn_start), .master_active(master_active),
    .cfg_rdata_r(), .cfg_rd_valid_r(), .line_size_r(), .bus_hold_limit_r(), .hold_count_r(),
    .hold_expired_r(), .window_base_r(p21_win));

  always #20 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic rd_chk(input string what, input logic [5:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    host.cfg_read(adr, d, ok);
    chk({what, "_valid"}, 32'h1, {31'h0, ok});
    chk(what, exp, d);
  endtask

  task automatic close_out();
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("line_size", 32'(LINE_SIZE_RST), 32'(line_size_r));
    chk("hold_limit", 32'h0, 32'(hold_limit_r));
    rd_chk("misc_rst", CFG_DW_MISC, 32'h0);
    for (int i = 0; i < 6; i++) begin
      chk("window_rst", exp_lo[i], window_base_r[i]);
    end
  endtask

  task automatic t_misc();
    host.cfg_write(CFG_DW_MISC, 4'hf, 32'hffff_ffff);
    rd_chk("misc_all", CFG_DW_MISC, 32'h0000_f8ff);
    chk("hold_out", 32'(HOLD_WR_MASK), 32'(hold_limit_r));
    chk("line_out", 32'hff, 32'(line_size_r));
    chk("tgt_line", 32'h0, 32'(tgt_line_size));
    chk("tgt_hold", 32'h0, 32'(tgt_hold_limit));
    chk("tgt_misc", 32'h0, tgt_rdata);
    // Only lane 0 enabled: the hold limit must not take the aa
    host.cfg_write(CFG_DW_MISC, 4'h1, 32'h0000_aa12);
    rd_chk("misc_lane", CFG_DW_MISC, 32'h0000_f812);
    chk("line_out2", 32'h12, 32'(line_size_r));
  endtask

  task automatic t_windows();
    for (int i = 0; i < 6; i++) begin
      host.cfg_write(CFG_DW_BAR0 + 6'(i), 4'hf, 32'hffff_ffff);
      rd_chk("window_ones", CFG_DW_BAR0 + 6'(i), exp_hi[i]);
      chk("window_out", exp_hi[i], window_base_r[i]);
      chk("p21_ones", exp21[i], p21_win[i]);
      host.cfg_write(CFG_DW_BAR0 + 6'(i), 4'hf, 32'h0000_0000);
      rd_chk("window_zero", CFG_DW_BAR0 + 6'(i), exp_lo[i]);
    end
    // Upper half of the pair keeps bits 31:8 at zero
    host.cfg_write(CFG_DW_BAR0 + 6'h1, 4'hf, 32'h1234_5678);
    rd_chk("upper_part", CFG_DW_BAR0 + 6'h1, 32'h0000_0078);
    host.cfg_write(CFG_DW_BAR0, 4'h8, 32'ha5a5_a5a5);
    rd_chk("lower_lane", CFG_DW_BAR0, 32'ha500_000c);
    rd_chk("unmapped_lo", 6'h00, 32'h0);
    rd_chk("unmapped_hi", 6'h3f, 32'h0);
  endtask

  // Mid-run reset: written values must fall back to their reset state
  task automatic t_rerst();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("line_rerst", 32'(LINE_SIZE_RST), 32'(line_size_r));
    chk("hold_rerst", 32'(HOLD_LIMIT_RST), 32'(hold_limit_r));
    chk("win0_rerst", exp_lo[0], window_base_r[0]);
    chk("win1_rerst", exp_lo[1], window_base_r[1]);
  endtask

  task automatic t_hold(input logic [7:0] lim);
    host.cfg_write(CFG_DW_MISC, 4'h2, {16'h0, lim, 8'h0});
    @(posedge core_clk);
    txn_start     <= 1'b1;
    master_active <= 1'b1;
    @(posedge core_clk);
    txn_start <= 1'b0;
    for (int k = 0; k <= int'(lim); k++) begin
      #1;
      chk("hold_count", 32'(int'(lim) - k), 32'(hold_count_r));
      chk("hold_expired", 32'(k == int'(lim)), 32'(hold_expired_r));
      chk("tgt_expired", 32'h0, 32'(tgt_expired));
      @(posedge core_clk);
    end
    master_active <= 1'b0;
    #1;
    chk("count_floor", 32'h0, 32'(hold_count_r));
    chk("expired_held", 32'h1, 32'(hold_expired_r));
    @(posedge core_clk);
    #1;
    chk("expired_clear", 32'h0, 32'(hold_expired_r));
    chk("tgt_count", 32'h0, 32'(tgt_hold_count));
  endtask

  initial begin
    core_clk      = 1'b0;
    sys_rst       = 1'b1;
    txn_start     = 1'b0;
    master_active = 1'b0;
    err_total     = 0;
    compares      = 0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_misc();
    t_windows();
    t_rerst();
    t_hold(8'h10);
    t_hold(8'h00);
    close_out();
  end

  // Whole run needs about 120 cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
